// file: hdl/sync_sram_pkg.sv
// Shared constants and types for the synchronous pipelined SRAM block.
package sync_sram_pkg;

    // Array geometry: full word address width and lane layout.
    localparam int ADDR_W = 18;
    localparam int MAX_LANES = 4;
    localparam int BYTE_W = 8;
    localparam int LANE_W = 9;

    // Burst sequencing: the two low address bits form the burst counter.
    localparam int BURST_W = 2;
    localparam logic [1:0] BURST_START = 2'h0;
    localparam logic [1:0] BURST_STEP = 2'h1;

    // Register byte addresses on the AXI4-Lite slave.
    localparam int REG_AW = 12;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_COUNT = 12'h008;

    // Field positions and reset values.
    localparam int CTRL_SNOOZE_BIT = 0;
    localparam logic CTRL_SNOOZE_RESET = 1'b0;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] COUNT_STEP = 32'h0000_0001;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Order in which a burst walks the two low address bits.
    typedef enum logic {
        ORDER_LINEAR = 1'b0,
        ORDER_INTERLEAVED = 1'b1
    } burst_order_e;

    // One pipeline stage of a registered access.
    typedef struct packed {
        logic sel;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [MAX_LANES-1:0] bw_n;
    } stage_s;

endpackage

// file: hdl/sync_sram_control.sv
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Address and burst bits registered at rising edge.
// - Data, enables and burst controls registered likewise.
// - Low byte enable writes only its lane.
// - Each byte enable gates data lane plus parity.
// - Parity stored only on parity-equipped variants.
// - Clock acts only when clock enable low.
// - Clock enable high freezes the access pipeline, not drivers or registers.
// - Read/write select alone sets cycle type.
// - Only new address load changes read/write.
// - All byte enables low writes whole word.
// - First chip enable sampled only at loads.
// - Selected needs second low, high-active high.
// - Snooze gives standby, array contents retained.
// - Snooze makes every other memory input ignored.
// - Load low loads address; high advances burst.
// - Burst order select: low linear, high interleaved.
// - Asynchronous output enable gates data drivers; here it is synchronised, so drivers follow it three edges later.
module sync_sram_control #(
    parameter int LANES = 4,
    parameter int PARITY = 1
) (
    // Clock and synchronous reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Synchronous memory control inputs.
    input wire logic [sync_sram_pkg::ADDR_W-3:0] sync_address_in,
    input wire logic burst_addr_bit0,
    input wire logic burst_addr_bit1,
    input wire logic [LANES-1:0] byte_wr_en_lane_n,
    input wire logic read_write_n,
    input wire logic clock_enable_n,
    input wire logic chip_select_first_n,
    input wire logic chip_select_second_n,
    input wire logic chip_select_high,
    input wire logic advance_or_load,
    input wire logic burst_order_select,
    // Asynchronous memory inputs.
    input wire logic snooze_request,
    input wire logic output_enable_n,
    // Data and parity bus, split into in, out and enable.
    input wire logic [LANES*sync_sram_pkg::BYTE_W-1:0] data_lane_in,
    input wire logic [LANES-1:0] parity_lane_in,
    output logic [LANES*sync_sram_pkg::BYTE_W-1:0] data_lane_out,
    output logic [LANES-1:0] parity_lane_out,
    output logic data_lane_oe,
    output logic parity_lane_oe,
    // AXI4-Lite write channels.
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int AW = sync_sram_pkg::ADDR_W;
    localparam int LW = sync_sram_pkg::LANE_W;
    localparam int BW = sync_sram_pkg::BYTE_W;

    // Storage array; each lane keeps eight data bits and one parity bit.
    logic [LANES*LW-1:0] mem [2**AW];

    // Two-flop synchronisers for the asynchronous pins.
    logic snooze_meta;
    logic snooze_sync;
    logic oe_n_meta;
    logic oe_n_sync;

    // Pipeline state: capture stage, access stage and burst counter.
    sync_sram_pkg::stage_s s1, next_s1;
    sync_sram_pkg::stage_s s2, next_s2;
    logic [1:0] base, next_base;
    logic [1:0] cnt, next_cnt;
    logic [LANES*LW-1:0] rd_data, next_rd_data;
    logic rd_live, next_rd_live;
    logic next_data_oe;
    logic [31:0] count, next_count;

    // Derived control terms.
    logic snoozing;
    logic en;
    logic load_sel;
    logic wr_now;

    // Register slave state.
    logic ctrl_snooze, next_ctrl_snooze;
    logic aw_full, next_aw_full;
    logic [sync_sram_pkg::REG_AW-1:0] aw_addr, next_aw_addr;
    logic w_full, next_w_full;
    logic [31:0] w_data, next_w_data;
    logic w_strb0, next_w_strb0;
    logic next_awready, next_wready, next_arready;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    // Asynchronous pins pass two flops before anything reads them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            snooze_meta <= 1'b0;
            snooze_sync <= 1'b0;
            oe_n_meta <= 1'b1;
            oe_n_sync <= 1'b1;
        end else begin
            snooze_meta <= snooze_request;
            snooze_sync <= snooze_meta;
            oe_n_meta <= output_enable_n;
            oe_n_sync <= oe_n_meta;
        end
    end

    // Snooze from the pin or from software stops the clock inside.
    assign snoozing = snooze_sync | ctrl_snooze;
    // Internal edges only while clock enable is low and not snoozing.
    assign en = !clock_enable_n && !snoozing;
    // All three chip enables must agree to select the device.
    assign load_sel = !chip_select_first_n && !chip_select_second_n &&
        chip_select_high;
    // Array write happens on the access stage of a selected write.
    assign wr_now = en && s2.sel && s2.write;

    // Next values of the access pipeline.
    always_comb begin
        next_s1 = s1;
        next_s2 = s2;
        next_base = base;
        next_cnt = cnt;
        next_rd_data = rd_data;
        next_rd_live = rd_live;
        next_count = count;
        // A stalled or snoozing edge leaves everything but the driver enable untouched.
        if (en) begin
            if (!advance_or_load) begin
                // New address: chip enables and type sampled only here.
                next_s1.sel = load_sel;
                next_s1.write = !read_write_n;
                next_s1.addr = {sync_address_in, burst_addr_bit1,
                    burst_addr_bit0};
                next_base = {burst_addr_bit1, burst_addr_bit0};
                next_cnt = sync_sram_pkg::BURST_START;
            end else begin
                // Advance: type and selection carry over from the load.
                next_cnt = cnt + sync_sram_pkg::BURST_STEP;
                if (burst_order_select == sync_sram_pkg::ORDER_INTERLEAVED)
                begin
                    next_s1.addr[1:0] = base ^ next_cnt;
                end else begin
                    next_s1.addr[1:0] = base + next_cnt;
                end
            end
            // Byte enables are taken on every enabled edge.
            next_s1.bw_n = '1;
            next_s1.bw_n[LANES-1:0] = byte_wr_en_lane_n;
            next_s2 = s1;
            // A selected read fetches its word one stage on.
            next_rd_live = s2.sel && !s2.write;
            if (s2.sel && !s2.write) begin
                next_rd_data = mem[s2.addr];
            end
            if (s2.sel) begin
                next_count = count + sync_sram_pkg::COUNT_STEP;
            end
        end
        // Drivers follow the output enable pin even while stalled.
        next_data_oe = next_rd_live && !oe_n_sync && !snoozing;
    end

    // Register the access pipeline.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1 <= '0;
            s2 <= '0;
            base <= sync_sram_pkg::BURST_START;
            cnt <= sync_sram_pkg::BURST_START;
            rd_data <= '0;
            rd_live <= 1'b0;
            data_lane_oe <= 1'b0;
            parity_lane_oe <= 1'b0;
            count <= sync_sram_pkg::COUNT_RESET;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            base <= next_base;
            cnt <= next_cnt;
            rd_data <= next_rd_data;
            rd_live <= next_rd_live;
            data_lane_oe <= next_data_oe;
            parity_lane_oe <= next_data_oe && (PARITY != 0);
            count <= next_count;
        end
    end

    // Array write: memories carry no reset, so they are written here.
    always_ff @(posedge aclk) begin
        if (aresetn && wr_now) begin
            for (int i = 0; i < LANES; i++) begin
                // Each low enable writes its byte and parity only.
                if (!s2.bw_n[i]) begin
                    mem[s2.addr][i*LW +: LW] <= {
                        parity_lane_in[i] & (PARITY != 0),
                        data_lane_in[i*BW +: BW]};
                end
            end
        end
    end

    // Read word is split back into data and parity lanes.
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            data_lane_out[i*BW +: BW] = rd_data[i*LW +: BW];
            parity_lane_out[i] = rd_data[i*LW + BW];
        end
    end

    // Next values of the register slave.
    always_comb begin
        next_ctrl_snooze = ctrl_snooze;
        next_aw_full = aw_full;
        next_aw_addr = aw_addr;
        next_w_full = w_full;
        next_w_data = w_data;
        next_w_strb0 = w_strb0;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        // Address and data are taken in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr[sync_sram_pkg::REG_AW-1:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // Both halves held and no response pending: perform the write.
        if (aw_full && w_full && !s_axi_bvalid) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = sync_sram_pkg::RESP_OKAY;
            if (aw_addr == sync_sram_pkg::REG_CTRL) begin
                if (w_strb0) begin
                    next_ctrl_snooze = w_data[sync_sram_pkg::CTRL_SNOOZE_BIT];
                end
            end else if (aw_addr != sync_sram_pkg::REG_STATUS &&
                aw_addr != sync_sram_pkg::REG_COUNT) begin
                next_bresp = sync_sram_pkg::RESP_SLVERR;
            end
        end
        next_awready = !next_aw_full;
        next_wready = !next_w_full;
        // Read: answered on the same edge that takes the address.
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = sync_sram_pkg::RESP_OKAY;
            case (s_axi_araddr[sync_sram_pkg::REG_AW-1:0])
                sync_sram_pkg::REG_CTRL: begin
                    next_rdata = {31'h0, ctrl_snooze};
                end
                sync_sram_pkg::REG_STATUS: begin
                    next_rdata = {28'h0, data_lane_oe, s1.write, s1.sel,
                        snoozing};
                end
                sync_sram_pkg::REG_COUNT: begin
                    next_rdata = count;
                end
                default: begin
                    next_rdata = 32'h0;
                    next_rresp = sync_sram_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_arready = !next_rvalid;
    end

    // Register the slave state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_snooze <= sync_sram_pkg::CTRL_SNOOZE_RESET;
            aw_full <= 1'b0;
            aw_addr <= '0;
            w_full <= 1'b0;
            w_data <= 32'h0;
            w_strb0 <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sync_sram_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= sync_sram_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0;
        end else begin
            ctrl_snooze <= next_ctrl_snooze;
            aw_full <= next_aw_full;
            aw_addr <= next_aw_addr;
            w_full <= next_w_full;
            w_data <= next_w_data;
            w_strb0 <= next_w_strb0;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // Checks on the access pipeline, all on the one clock.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // A selected read load followed by two enabled edges.
    sequence seq_read_load;
        en && !advance_or_load && load_sel && read_write_n;
    endsequence
    sequence seq_two_edges;
        en ##1 en;
    endsequence

    chk_addr_capture: assert property (
        (en && !advance_or_load) |=> s1.addr[AW-1:2] == $past(sync_address_in))
        else $error("load address not captured");
    chk_clock_hold: assert property (
        !en |=> $stable(s1) && $stable(s2) && $stable(rd_data))
        else $error("state moved while clock disabled");
    chk_type_kept: assert property (
        (en && advance_or_load) |=> s1.write == $past(s1.write))
        else $error("cycle type changed without a load");
    chk_select_kept: assert property (
        (en && advance_or_load) |=> s1.sel == $past(s1.sel))
        else $error("chip enable sampled during advance");
    chk_deselect_load: assert property (
        (en && !advance_or_load && !load_sel) |=> !s1.sel ##1 !s2.sel)
        else $error("deselected load still selected");
    chk_lane_write: assert property (
        (wr_now && !s2.bw_n[0]) |=>
        mem[$past(s2.addr)][BW-1:0] == $past(data_lane_in[BW-1:0]))
        else $error("lane a write lost");
    chk_snooze_quiet: assert property (
        snoozing |=> !data_lane_oe && !wr_now)
        else $error("activity while snoozing");
    chk_oe_gate: assert property (
        oe_n_sync |=> !data_lane_oe)
        else $error("drivers on with output enable high");
    chk_read_pipe: assert property (
        seq_read_load ##1 seq_two_edges |->
        (s2.sel && !s2.write) ##1 rd_live)
        else $error("read load did not reach the output stage");

endmodule

`default_nettype wire

// file: bench/host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none

// Host side of the shared data and parity bus: resolves the wire level.
module host_bus_model (
    // Clock.
    input wire logic aclk,
    // Host side of the bus.
    input wire logic host_drive,
    input wire logic [35:0] host_data,
    // Memory side of the bus.
    input wire logic dev_data_oe,
    input wire logic dev_par_oe,
    input wire logic [35:0] dev_data,
    // Level seen on the wire.
    output logic [35:0] bus_level
);
    // Last wire level, so a released bus never repeats it.
    logic [35:0] last_level = 36'h0;

    // Record the wire at every edge.
    always_ff @(posedge aclk) begin
        last_level <= bus_level;
    end

    // A driver wins; a released bus shows the inverse of its last value.
    always_comb begin
        bus_level = ~last_level;
        if (host_drive) begin
            bus_level = host_data;
        end
        if (dev_data_oe) begin
            bus_level[31:0] = dev_data[31:0];
        end
        if (dev_par_oe) begin
            bus_level[35:32] = dev_data[35:32];
        end
    end
endmodule

`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// Self-checking bench for the SRAM control block.
module tb_top;
    localparam logic [2:0] SEL = 3'b001;
    localparam logic [2:0] DESEL = 3'b101;
    // Clock, reset and memory inputs driven by the host.
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic adv = 1'b0;
    logic rw_n = 1'b1;
    logic [17:0] addr = 18'h0;
    logic [3:0] bw_n = 4'hf;
    logic [2:0] sel = DESEL;
    logic cke_n = 1'b0;
    logic zz = 1'b0;
    logic oe_n = 1'b0;
    logic order = 1'b1;
    logic host_drive = 1'b0;
    logic [35:0] host_data = 36'h0;
    // Bus wires and design outputs.
    logic [35:0] bus_level;
    logic [31:0] data_lane_out;
    logic [3:0] parity_lane_out;
    logic data_lane_oe;
    logic parity_lane_oe;
    // AXI4-Lite master signals.
    logic [31:0] awaddr = 32'h0;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [31:0] araddr = 32'h0;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    // Expected array words at 0x40..0x43 and the last word read.
    logic [35:0] exp_mem [4];
    logic [35:0] last_rd = 36'h0;
    int fail_count = 0;
    int n_checks = 0;

    always #10 aclk = ~aclk;

    sync_sram_control #(.LANES(4), .PARITY(1)) sync_sram_control_inst (
        .aclk(aclk), .aresetn(aresetn),
        .sync_address_in(addr[17:2]), .burst_addr_bit0(addr[0]),
        .burst_addr_bit1(addr[1]), .byte_wr_en_lane_n(bw_n),
        .read_write_n(rw_n), .clock_enable_n(cke_n),
        .chip_select_first_n(sel[2]), .chip_select_second_n(sel[1]),
        .chip_select_high(sel[0]), .advance_or_load(adv),
        .burst_order_select(order), .snooze_request(zz),
        .output_enable_n(oe_n), .data_lane_in(bus_level[31:0]),
        .parity_lane_in(bus_level[35:32]), .data_lane_out(data_lane_out),
        .parity_lane_out(parity_lane_out), .data_lane_oe(data_lane_oe),
        .parity_lane_oe(parity_lane_oe), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    host_bus_model host_bus_model_inst (
        .aclk(aclk), .host_drive(host_drive), .host_data(host_data),
        .dev_data_oe(data_lane_oe), .dev_par_oe(parity_lane_oe),
        .dev_data({parity_lane_out, data_lane_out}), .bus_level(bus_level));

    // Compare one value, count it and report a difference.
    task automatic cmp(input logic [35:0] got, input logic [35:0] want);
        n_checks++;
        if (got !== want) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h want=%h", $time, got, want);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One memory bus cycle, set up just after a rising edge.
    task automatic cyc(input logic a_ld, input logic rw, input logic [17:0] a,
                       input logic [3:0] b, input logic [2:0] s);
        @(posedge aclk);
        adv <= a_ld;
        rw_n <= rw;
        addr <= a;
        bw_n <= b;
        sel <= s;
    endtask

    // Write cycle; the host drives data in the cycles before the array write.
    task automatic mem_write(input logic [17:0] a, input logic [35:0] d,
                             input logic [3:0] b, input logic [2:0] s);
        cyc(1'b0, 1'b0, a, b, s);
        cyc(1'b0, 1'b1, 18'h0, b, DESEL);
        host_data <= d;
        host_drive <= 1'b1;
        cyc(1'b0, 1'b1, 18'h0, b, DESEL);
        cyc(1'b0, 1'b1, 18'h0, 4'hf, DESEL);
        host_drive <= 1'b0;
    endtask

    // Read cycle; a deselected load must leave the old word and no driver.
    task automatic mem_read(input logic [17:0] a, input logic [2:0] s);
        logic [35:0] want;
        want = (s == SEL) ? exp_mem[a[1:0]] : last_rd;
        cyc(1'b0, 1'b1, a, 4'hf, s);
        cyc(1'b0, 1'b1, 18'h0, 4'hf, DESEL);
        cyc(1'b0, 1'b1, 18'h0, 4'hf, DESEL);
        @(posedge aclk);
        #1;
        cmp({parity_lane_out, data_lane_out}, want);
        cmp({data_lane_oe, parity_lane_oe}, {2{s == SEL && !oe_n}});
        last_rd = want;
    endtask

    // AXI4-Lite write; each channel is released once it is taken.
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                             input logic [1:0] er);
        @(posedge aclk);
        awaddr <= {20'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        cmp({34'h0, bresp}, {34'h0, er});
    endtask

    // AXI4-Lite read; the address is released once it is taken.
    task automatic axi_read(input logic [11:0] a, input logic [31:0] ed,
                            input logic [1:0] er);
        @(posedge aclk);
        araddr <= {20'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        cmp({2'h0, rresp, rdata}, {2'h0, er, ed});
    endtask

    // Registers: reset values, read back, unmapped places refused.
    task automatic reg_scn;
        axi_read(sync_sram_pkg::REG_COUNT, sync_sram_pkg::COUNT_RESET,
                 sync_sram_pkg::RESP_OKAY);
        axi_read(sync_sram_pkg::REG_CTRL, 32'h0, sync_sram_pkg::RESP_OKAY);
        axi_read(12'h00c, 32'h0, sync_sram_pkg::RESP_SLVERR);
        axi_write(12'h010, 32'h1, sync_sram_pkg::RESP_SLVERR);
        axi_write(sync_sram_pkg::REG_CTRL, 32'h1, sync_sram_pkg::RESP_OKAY);
        axi_read(sync_sram_pkg::REG_CTRL, 32'h1, sync_sram_pkg::RESP_OKAY);
        axi_write(sync_sram_pkg::REG_CTRL, 32'h0, sync_sram_pkg::RESP_OKAY);
    endtask

    // Burst from 0x41 in either order; advances carry a write and CE off.
    task automatic burst_scn(input logic ord);
        int i;
        order <= ord;
        cyc(1'b0, 1'b1, 18'h41, 4'hf, SEL);
        for (i = 0; i < 6; i++) begin
            if (i < 3) cyc(1'b1, 1'b0, 18'h0, 4'hf, DESEL);
            else if (i == 3) cyc(1'b0, 1'b1, 18'h0, 4'hf, DESEL);
            else @(posedge aclk);
            #1;
            if (i >= 2) cmp({parity_lane_out, data_lane_out},
                ord ? exp_mem[2'h1 ^ 2'(i - 2)] :
                exp_mem[2'h1 + 2'(i - 2)]);
        end
        last_rd = exp_mem[ord ? 2'h2 : 2'h0];
    endtask

    // Clock enable high for three edges must stretch the read pipeline.
    task automatic stall_scn;
        cyc(1'b0, 1'b1, 18'h43, 4'hf, SEL);
        cyc(1'b0, 1'b1, 18'h0, 4'hf, DESEL);
        cke_n <= 1'b1;
        repeat (3) @(posedge aclk);
        #1;
        cmp({parity_lane_out, data_lane_out}, last_rd);
        cke_n <= 1'b0;
        repeat (2) @(posedge aclk);
        #1;
        cmp({parity_lane_out, data_lane_out}, exp_mem[3]);
        last_rd = exp_mem[3];
    endtask

    // Main sequence.
    initial begin
        int k;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reg_scn();
        for (k = 0; k < 4; k++) begin
            exp_mem[k] = {4'h9 ^ 4'(k), 32'h5a5a_0000 | 32'(k * 32'h111)};
            mem_write(18'h40 + 18'(k), exp_mem[k], 4'h0, SEL);
        end
        for (k = 0; k < 4; k++) mem_read(18'h40 + 18'(k), SEL);
        mem_write(18'h40, 36'hf_ffff_ffff, 4'b1101, SEL);
        exp_mem[0][15:8] = 8'hff;
        exp_mem[0][33] = 1'b1;
        mem_read(18'h40, SEL);
        burst_scn(1'b1);
        burst_scn(1'b0);
        stall_scn();
        mem_write(18'h41, 36'h0, 4'h0, 3'b101);
        mem_write(18'h41, 36'h0, 4'h0, 3'b011);
        mem_write(18'h41, 36'h0, 4'h0, 3'b000);
        mem_read(18'h41, SEL);
        mem_read(18'h42, 3'b000);
        zz <= 1'b1;
        repeat (4) @(posedge aclk);
        mem_write(18'h42, 36'h0, 4'h0, SEL);
        zz <= 1'b0;
        repeat (4) @(posedge aclk);
        mem_read(18'h42, SEL);
        oe_n <= 1'b1;
        repeat (4) @(posedge aclk);
        mem_read(18'h43, SEL);
        report_and_stop();
    end

    // Watchdog against a hung handshake.
    initial begin
        repeat (5000) @(posedge aclk);
        fail_count++;
        report_and_stop();
    end
endmodule

`default_nettype wire
